//--- core/rmd_decode.sv
`timescale 1ns/1ps
module rmd_decode #(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000,
  parameter int          NUM_CPUS  = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_valid_i,
  input  rmd_pkg::rmd_req_t       req_i,
  output logic                    req_ready_o,
  output logic                    rsp_valid_o,
  output logic [31:0]             rsp_rdata_o,
  output logic                    rsp_slverr_o,
  output logic                    tgt_valid_o,
  output rmd_pkg::rmd_tgt_t       tgt_o,
  input  rmd_pkg::rmd_trsp_t      tgt_rsp_i
);
  import rmd_pkg::*;

  ////////////////////////////////////////////////////////////////
  // Declarations

  rmd_state_t          s_q;        // Registered state
  rmd_state_t          s_d;        // Next state
  logic                fire;       // Request taken this cycle
  logic [OFS_W-1:0]    ofs;        // Offset from base
  logic [2:0]          rgn;        // 4 KB page index
  logic [11:0]         lofs;       // Offset inside page
  logic                in_win;     // Address inside our window
  logic                byte_ok;    // Sub-word sizes allowed
  logic                misalign;   // Size and address disagree
  logic                bad_size;   // Answer with SLVERR
  logic                sec_only;   // Secure-only area hit
  logic                raz;        // Read zero, drop write
  logic [LANES-1:0]    strb;       // Byte lanes of request
  rmd_tgt_t            dec_tgt;    // Decoded target request
  logic [DATA_W-1:0]   lane_m;     // Bit mask of live lanes

  ////////////////////////////////////////////////////////////////
  // Address decode

  // Split the address into window, page and local offset
  // base from parameter
  always_comb begin
    in_win = req_i.addr[ADDR_W-1:OFS_W] == BASE_ADDR[ADDR_W-1:OFS_W];
    ofs    = req_i.addr[OFS_W-1:0];
    rgn    = ofs[OFS_W-1:RGN_LSB];
    lofs   = ofs[RGN_LSB-1:0];
  end

  // Lane strobes, little-endian only
  // low address, low lane
  always_comb begin
    strb     = STB_ALL;
    misalign = 1'b0;
    unique case (req_i.size)
      SZ_BYTE: begin
        strb = STB_ONE << req_i.addr[1:0];
      end
      SZ_HALF: begin
        // Halfword must sit on an even byte
        strb     = req_i.addr[1] ? STB_HIH : STB_LOH;
        misalign = req_i.addr[0];
      end
      SZ_WORD: begin
        misalign = req_i.addr[1:0] != 2'h0;
      end
      default: begin
        // Unused size code is always refused
        misalign = 1'b1;
      end
    endcase
  end

  // Which distributor areas accept bytes and halfwords
  // halfword wherever byte
  always_comb begin
    byte_ok = (rgn == RGN_DIST) &&
              (((lofs >= PRIO_LO) && (lofs <= TGT_HI)) ||
               ((lofs >= SGIP_LO) && (lofs <= SGIP_HI)));
  end

  // Size check; word accesses are always legal by size
  // refuse illegal sub-word
  always_comb begin
    bad_size = misalign || ((req_i.size != SZ_WORD) && !byte_ok);
  end

  // Group registers hide from Non-secure requesters
  // secure-only group area
  always_comb begin
    sec_only = (rgn == RGN_DIST) && !req_i.secure &&
               (lofs >= GRP_LO) && (lofs <= GRP_HI);
  end

  // Route page to block, pick bank and local offset
  // page routing
  always_comb begin
    dec_tgt        = '0;
    dec_tgt.wr     = req_i.wr;
    dec_tgt.strb   = strb;
    dec_tgt.wdata  = req_i.wdata;
    dec_tgt.secure = req_i.secure;
    dec_tgt.cpu    = req_i.cpu;
    raz            = !in_win;
    unique case (rgn)
      RGN_DIST: begin
        dec_tgt.blk = BLK_DIST;
        dec_tgt.ofs = {1'b0, lofs};
      end
      RGN_CPU0, RGN_CPU1: begin
        // Processor interfaces span two pages
        dec_tgt.blk = BLK_CPUIF;
        dec_tgt.ofs = ofs[TOFS_W-1:0];
      end
      RGN_VOWN: begin
        dec_tgt.blk = BLK_VCTRL;
        dec_tgt.ofs = {1'b0, lofs};
      end
      RGN_VSEL: begin
        dec_tgt.blk = BLK_VCTRL;
        dec_tgt.cpu = lofs[ALIAS_MSB:ALIAS_LSB];
        dec_tgt.ofs = {{(TOFS_W-ALIAS_LSB){1'b0}},
                       lofs[ALIAS_LSB-1:0]};
        // Alias of an absent processor is empty
        if (int'(lofs[ALIAS_MSB:ALIAS_LSB]) >= NUM_CPUS) begin
          raz = 1'b1;
        end
      end
      RGN_VCPU0, RGN_VCPU1: begin
        dec_tgt.blk = BLK_VCPU;
        dec_tgt.ofs = ofs[TOFS_W-1:0];
      end
      default: begin
        raz = 1'b1;
      end
    endcase
    if (sec_only) begin
      raz = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read lane mask

  // Zero the lanes the access did not ask for
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign lane_m[LANE_W*g +: LANE_W] = {LANE_W{s_q.tgt.strb[g]}};
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer

  assign fire = (s_q.st == ST_IDLE) && req_valid_i;

  // Take, forward, answer; one request in flight
  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      ST_IDLE: begin
        if (req_valid_i) begin
          s_d.tgt   = dec_tgt;
          s_d.rdata = '0;
          s_d.err   = 1'b0;
          if (raz) begin
            s_d.st = ST_RSP;
          end else if (bad_size) begin
            s_d.err = 1'b1;
            s_d.st  = ST_RSP;
          end else begin
            s_d.st = ST_FWD;
          end
        end
      end
      ST_FWD: begin
        // Block may take any number of cycles
        if (tgt_rsp_i.ack) begin
          s_d.rdata = s_q.tgt.wr ? '0 : (tgt_rsp_i.rdata & lane_m);
          s_d.err   = tgt_rsp_i.err;
          s_d.st    = ST_RSP;
        end
      end
      ST_RSP: begin
        s_d.st = ST_IDLE;
      end
      default: begin
        // Broken one-hot code recovers to idle
        s_d = ST_RESET;
      end
    endcase
    if (rst_i) begin
      s_d = ST_RESET;
    end
  end

  // Single state register
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  assign req_ready_o  = s_q.st == ST_IDLE;
  assign tgt_valid_o  = s_q.st == ST_FWD;
  assign tgt_o        = s_q.tgt;
  assign rsp_valid_o  = s_q.st == ST_RSP;
  assign rsp_rdata_o  = s_q.rdata;
  assign rsp_slverr_o = s_q.err;

  ////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_idle: assert property (
    $past(rst_i) |-> req_ready_o && !rsp_valid_o && !tgt_valid_o)
    else $error("decoder not idle after reset");

  a_base_window: assert property (
    fire && !in_win |=> rsp_valid_o && rsp_rdata_o == '0 && !rsp_slverr_o)
    else $error("access outside window not RAZ");

  a_reserved_raz: assert property (
    fire && rgn == RGN_RSVD |=> rsp_valid_o && !tgt_valid_o && rsp_rdata_o == '0)
    else $error("reserved page not RAZ/WI");

  a_port_answer: assert property (
    tgt_valid_o && tgt_rsp_i.ack |=> rsp_valid_o ##1 req_ready_o)
    else $error("block answer not returned next cycle");

  a_half_ok: assert property (
    fire && in_win && byte_ok && req_i.size == SZ_HALF && !req_i.addr[0]
      |=> tgt_valid_o)
    else $error("legal halfword not forwarded");

  a_size_err: assert property (
    fire && in_win && rgn == RGN_CPU0 && req_i.size == SZ_BYTE
      |=> rsp_valid_o && rsp_slverr_o && !tgt_valid_o)
    else $error("illegal byte access not refused");

  a_byte_lane: assert property (
    fire && req_i.size == SZ_BYTE |=> tgt_o.strb == (STB_ONE << $past(req_i.addr[1:0])))
    else $error("byte lane not little-endian");

  a_dist_route: assert property (
    fire && !raz && !bad_size && rgn == RGN_DIST |=> tgt_valid_o && tgt_o.blk == BLK_DIST)
    else $error("distributor page misrouted");

  a_own_alias: assert property (
    fire && !raz && !bad_size && rgn == RGN_VOWN
      |=> tgt_o.blk == BLK_VCTRL && tgt_o.cpu == $past(req_i.cpu))
    else $error("own alias picked wrong processor");

  a_sel_alias: assert property (
    fire && !raz && !bad_size && rgn == RGN_VSEL
      |=> tgt_o.cpu == $past(req_i.addr[ALIAS_MSB:ALIAS_LSB]) &&
          tgt_o.ofs < (TOFS_W'(1) << ALIAS_LSB))
    else $error("processor alias decode wrong");

  a_secure_bank: assert property (
    fire && !raz && !bad_size |=> tgt_o.secure == $past(req_i.secure))
    else $error("security bank not from request");

  a_secure_only: assert property (
    fire && sec_only |=> rsp_valid_o && rsp_rdata_o == '0 && !tgt_valid_o)
    else $error("Non-secure reached group register");

  // Reset leaves no stale data or target request behind
  a_reset_clear: assert property (
    $past(rst_i) |-> rsp_rdata_o == '0 && !rsp_slverr_o && tgt_o == '0)
    else $error("decoder data not cleared by reset");

  // Banked copy follows the requester outside the selecting alias
  a_cpu_bank: assert property (
    fire && !raz && !bad_size && rgn != RGN_VSEL |=> tgt_o.cpu == $past(req_i.cpu))
    else $error("bank select not from requester");

  // Secure requester does reach the group registers
  a_group_secure: assert property (
    fire && in_win && rgn == RGN_DIST && req_i.secure && !bad_size &&
      (lofs >= GRP_LO) && (lofs <= GRP_HI) |=> tgt_valid_o && tgt_o.blk == BLK_DIST)
    else $error("Secure group access not forwarded");

  // Halfword lanes follow address bit 1, low half first
  a_half_lane: assert property (
    fire && req_i.size == SZ_HALF
      |=> tgt_o.strb == ($past(req_i.addr[1]) ? STB_HIH : STB_LOH))
    else $error("halfword lane not little-endian");

  // Main scenarios seen at least once
  c_sub_word: cover property (fire && byte_ok && req_i.size != SZ_WORD && !bad_size);
  c_forward: cover property (fire ##1 tgt_valid_o [*2] ##1 rsp_valid_o);
  c_slverr: cover property (rsp_valid_o && rsp_slverr_o);
  c_sel_alias: cover property (fire && rgn == RGN_VSEL && !raz);
  c_ns_group: cover property (fire && sec_only);

endmodule

//--- core/rmd_pkg.sv
// Operation
// - Fixed offsets, base chosen at integration
// - Reserved locations read zero, ignore writes
// - All data clears to zero on reset; sequencer returns to ST_IDLE
// - Register port carries 32-bit words
// - Byte-capable registers also take halfwords
// - Illegal sub-word size answers with SLVERR
// - Little-endian byte lanes only
// - Route distributor, processor, virtual interface regions
// - 0x4000 region reaches requester's control block
// - 0x5000 region selects processor by bits 11:9
// - Secure access selects Secure banked copy
// - Per-processor copies selected by requester
// - Group registers reachable by Secure only
// - Non-secure touch of Secure part: RAZ/WI
package rmd_pkg;

  // Bus geometry
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 32;
  localparam int OFS_W   = 15;
  localparam int RGN_LSB = 12;
  localparam int TOFS_W  = 13;
  localparam int CPU_W   = 3;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;

  // Regions, one per 4 KB page of the map
  localparam logic [2:0] RGN_RSVD  = 3'h0;
  localparam logic [2:0] RGN_DIST  = 3'h1;
  localparam logic [2:0] RGN_CPU0  = 3'h2;
  localparam logic [2:0] RGN_CPU1  = 3'h3;
  localparam logic [2:0] RGN_VOWN  = 3'h4;
  localparam logic [2:0] RGN_VSEL  = 3'h5;
  localparam logic [2:0] RGN_VCPU0 = 3'h6;
  localparam logic [2:0] RGN_VCPU1 = 3'h7;

  // Processor-select alias: 512 bytes per processor
  localparam int ALIAS_LSB = 9;
  localparam int ALIAS_MSB = 11;

  // Distributor windows, local 12-bit offsets
  localparam logic [11:0] GRP_LO  = 12'h080;
  localparam logic [11:0] GRP_HI  = 12'h0BF;
  localparam logic [11:0] PRIO_LO = 12'h400;
  localparam logic [11:0] TGT_HI  = 12'hBFF;
  localparam logic [11:0] SGIP_LO = 12'hF10;
  localparam logic [11:0] SGIP_HI = 12'hF2F;

  // Access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Lane strobes
  localparam logic [3:0] STB_ONE = 4'h1;
  localparam logic [3:0] STB_LOH = 4'h3;
  localparam logic [3:0] STB_HIH = 4'hC;
  localparam logic [3:0] STB_ALL = 4'hF;

  // Target block select, one-hot except BLK_NONE, which is all zero
  typedef enum logic [3:0] {
    BLK_NONE  = 4'h0,
    BLK_DIST  = 4'h1,
    BLK_CPUIF = 4'h2,
    BLK_VCTRL = 4'h4,
    BLK_VCPU  = 4'h8
  } rmd_blk_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FWD  = 3'h2,
    ST_RSP  = 3'h4
  } rmd_st_t;

  // Bus request with its attributes
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic [1:0]        size;
    logic [DATA_W-1:0] wdata;
    logic              secure;
    logic [CPU_W-1:0]  cpu;
  } rmd_req_t;

  // Request towards a functional block
  typedef struct packed {
    rmd_blk_t          blk;
    logic [TOFS_W-1:0] ofs;
    logic              wr;
    logic [LANES-1:0]  strb;
    logic [DATA_W-1:0] wdata;
    logic              secure;
    logic [CPU_W-1:0]  cpu;
  } rmd_tgt_t;

  // Answer from a functional block
  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } rmd_trsp_t;

  // Whole state of the decoder
  typedef struct packed {
    rmd_st_t           st;
    rmd_tgt_t          tgt;
    logic [DATA_W-1:0] rdata;
    logic              err;
  } rmd_state_t;

  localparam rmd_state_t ST_RESET = '{
    st: ST_IDLE, tgt: '0, rdata: '0, err: 1'b0};

endpackage

//--- tb/rmd_blk_model.sv
`timescale 1ns/1ps
module rmd_blk_model (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          tgt_valid_i,
  input  rmd_pkg::rmd_tgt_t  tgt_i,
  input  wire logic [3:0]    delay_i,
  input  wire logic          err_i,
  output rmd_pkg::rmd_trsp_t rsp_o
);
  import rmd_pkg::*;
  logic [3:0]  cnt_q;  // Cycles waited so far
  logic        ack_q;  // One-cycle acknowledge
  logic [31:0] junk_q; // Idle pattern, changes every cycle out of reset so stale data never looks valid

  ////////////////////////////////////////////////////////////////
  // Acknowledge after the commanded wait, once per forwarded request
  always_ff @(posedge clk_i) begin
    if (rst_i || !tgt_valid_i) begin
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (ack_q) begin
      ack_q <= 1'b0;
    end else if (cnt_q == delay_i) begin
      ack_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
    junk_q <= rst_i ? 32'h0000_0000 : junk_q + 32'h9E37_79B9;
  end

  ////////////////////////////////////////////////////////////////
  // banked copy by attributes
  assign rsp_o.ack   = ack_q;
  assign rsp_o.err   = ack_q ? err_i : junk_q[0];
  assign rsp_o.rdata = ack_q ? {3'h5, tgt_i.blk, tgt_i.secure, tgt_i.cpu, 8'h5A, tgt_i.ofs}
                             : junk_q;
endmodule

//--- tb/rmd_decode_tb.sv
`timescale 1ns/1ps
module rmd_decode_tb;
  import rmd_pkg::*;
  localparam logic [31:0] BASE = 32'h0002_8000; // 32 KB aligned
  localparam int          NCPU = 6;             // Leaves aliases 6 and 7 empty
  localparam logic [11:0] GP[4] = '{12'h07C, 12'h080, 12'h0BC, 12'h0C0}; // Group edges
  localparam logic [31:0] SP[4] = '{32'h1400, 32'h1F2C, 32'h1F30, 32'h2000}; // Size probes
  // Expected outcome of one request
  typedef struct packed {
    logic              fwd;
    rmd_tgt_t          tgt;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } rmd_note_t;
  logic        clk_i, rst_i, req_valid_i, req_ready_o, rsp_valid_o, rsp_slverr_o;
  logic        tgt_valid_o, m_err;
  logic [31:0] rsp_rdata_o, rng;
  logic [3:0]  m_delay;
  rmd_req_t    req_i;
  rmd_tgt_t    tgt_o;
  rmd_trsp_t   tgt_rsp_i;
  rmd_note_t   q[$];
  rmd_note_t   h;
  int          fail_count, tests_run;

  rmd_decode #(.BASE_ADDR(BASE), .NUM_CPUS(NCPU)) u_rmd_decode (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .rsp_slverr_o(rsp_slverr_o), .tgt_valid_o(tgt_valid_o), .tgt_o(tgt_o),
    .tgt_rsp_i(tgt_rsp_i));
  rmd_blk_model u_rmd_blk_model (
    .clk_i(clk_i), .rst_i(rst_i), .tgt_valid_i(tgt_valid_o), .tgt_i(tgt_o),
    .delay_i(m_delay), .err_i(m_err), .rsp_o(tgt_rsp_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Decode worked out independently of the design
  function automatic rmd_note_t predict(input rmd_req_t r, input logic er);
    rmd_note_t   e;
    logic [11:0] lo;
    logic        raz, bad, sub;
    e = '0;
    lo = r.addr[11:0];
    e.tgt.wr = r.wr;
    e.tgt.secure = r.secure;
    e.tgt.cpu = r.cpu;
    e.tgt.ofs = r.addr[12:0];
    e.tgt.blk = BLK_VCPU;
    e.tgt.strb = r.size == SZ_WORD ? STB_ALL : r.size == SZ_HALF ?
                 (r.addr[1] ? STB_HIH : STB_LOH) : STB_ONE << r.addr[1:0];
    raz = r.addr[31:15] != BASE[31:15];
    case (r.addr[14:12])
      RGN_RSVD: raz = 1'b1;
      RGN_DIST: begin
        e.tgt.blk = BLK_DIST;
        e.tgt.ofs = {1'b0, lo};
        raz |= !r.secure && lo >= GRP_LO && lo <= GRP_HI;
      end
      RGN_CPU0, RGN_CPU1: e.tgt.blk = BLK_CPUIF;
      RGN_VOWN: begin
        e.tgt.blk = BLK_VCTRL;
        e.tgt.ofs = {1'b0, lo};
      end
      RGN_VSEL: begin
        e.tgt.blk = BLK_VCTRL;
        e.tgt.ofs = {4'h0, lo[8:0]};
        e.tgt.cpu = lo[11:9];
        raz |= lo[11:9] >= NCPU;
      end
      default: ;
    endcase
    sub = e.tgt.blk == BLK_DIST &&
          ((lo >= PRIO_LO && lo <= TGT_HI) || (lo >= SGIP_LO && lo <= SGIP_HI));
    bad = r.size == 2'h3 || (r.size == SZ_HALF && r.addr[0]) ||
          (r.size == SZ_WORD && r.addr[1:0] != 2'h0) || (r.size != SZ_WORD && !sub);
    e.fwd = !raz && !bad;
    e.err = e.fwd ? er : !raz && bad;
    if (e.fwd && !r.wr) e.rdata = {3'h5, e.tgt.blk, e.tgt.secure, e.tgt.cpu, 8'h5A,
                                   e.tgt.ofs} & lanes(e.tgt.strb);
    return e;
  endfunction

  task automatic chk_tgt(input logic [$bits(rmd_tgt_t):0] got,
                         input logic [$bits(rmd_tgt_t):0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t target got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t answer got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hold reset two cycles, release, then check the cleared state
  task automatic pulse_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_tgt({tgt_valid_o, tgt_o}, '0);
    chk_rsp({req_ready_o, rsp_valid_o | rsp_slverr_o, rsp_rdata_o}, {2'b10, 32'h0});
  endtask

  // One request: note it, present it, hold until taken; bounded waits
  task automatic send(input logic [31:0] a, input logic w, input logic [1:0] sz,
                      input logic s, input logic [2:0] c, input logic [3:0] d,
                      input logic er);
    rmd_req_t  r;
    rmd_note_t e;
    int        k;
    r = '{addr: a, wr: w, size: sz, wdata: '0, secure: s, cpu: c};
    e = predict(r, er & w);
    if (w) r.wdata = xs(rng) & lanes(e.tgt.strb);
    e.tgt.wdata = r.wdata;
    k = 0;
    @(posedge clk_i);
    while (q.size() > 0 && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    q.push_back(e);
    req_i <= r;
    req_valid_i <= 1'b1;
    m_delay <= d;
    m_err <= er & w;
    do begin
      @(posedge clk_i);
      k++;
    end while (!req_ready_o && k < 60);
    req_valid_i <= 1'b0;
    rng = xs(rng);
    if (k >= 60) begin
      fail_count++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////
  // Watcher: forwarded request checked every cycle it stands, answers in order
  always @(posedge clk_i) begin
    if (!rst_i) begin
      h = q.size() > 0 ? q[0] : '0;
      if (tgt_valid_o) chk_tgt({1'b1, tgt_o}, {h.fwd, h.tgt});
      if (rsp_valid_o) begin
        chk_rsp({q.size() > 0, rsp_slverr_o, rsp_rdata_o}, {1'b1, h.err, h.rdata});
        if (q.size() > 0) void'(q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    m_delay = 4'h0;
    m_err = 1'b0;
    rng = 32'h335F_AD23;
    fail_count = 0;
    tests_run = 0;
    pulse_reset();
    send(BASE + 32'h0000_9400, 1'b1, SZ_BYTE, 1'b1, 3'h0, 4'h0, 1'b0);
    send(32'h0000_1000, 1'b0, SZ_WORD, 1'b1, 3'h0, 4'h0, 1'b0);
    for (int i = 0; i < 16; i++) send(BASE + {i[3:0], 11'h104}, i[1], SZ_WORD, i[0], i[3:1],
                                      i[3:0], i == 14);
    for (int i = 0; i < 8; i++) send(BASE + 32'h0000_5008 + {i[2:0], 9'h000}, i[0], SZ_WORD,
                                     1'b1, 3'h2, 4'h1, 1'b0);
    // Reset while a read waits on the block: dropped, never answered
    for (int n = 0; n < 60 && q.size() > 0; n++) @(posedge clk_i);
    req_i <= '{addr: BASE + 32'h0000_2000, wr: 1'b0, size: SZ_WORD, wdata: '0,
               secure: 1'b1, cpu: 3'h1};
    req_valid_i <= 1'b1;
    m_delay <= 4'hF;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    pulse_reset();
    for (int i = 0; i < 16; i++) send(BASE + 32'h0000_1000 + GP[i[3:2]], i[0], SZ_WORD, i[1],
                                      3'h3, 4'h0, 1'b0);
    for (int i = 0; i < 64; i++) send(BASE + SP[i[5:4]] + i[1:0], i[1] ^ i[3], i[3:2], 1'b1,
                                      i[2:0], 4'h2, 1'b0);
    repeat (80) send({BASE[31:15], rng[14:0]}, rng[15], rng[17:16], rng[18], rng[21:19],
                     rng[25:22], rng[26]);
    repeat (20) @(posedge clk_i);
    // A request still waiting for its answer means the run hung
    if (q.size() > 0) fail_count++;
    give_verdict();
  end
endmodule
